// ==== hw/trig_seq_pkg.sv ====
`default_nettype none
package trig_seq_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_DEBOUNCE = 12'h004;
    localparam logic [11:0] ADDR_EXPOSURE = 12'h008;
    localparam logic [11:0] ADDR_READOUT = 12'h00C;
    localparam logic [11:0] ADDR_SWTRIG = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_PULSE_MODE_BIT = 1;
    localparam int CTRL_NEG_POL_BIT = 2;
    localparam int CTRL_SRC_BIT = 3;
    localparam int CTRL_OVERLAP_BIT = 4;
    localparam int CTRL_LINE_OUT_BIT = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0010;

    // ------------------------------------------------------------
    // Reset values of timing registers, in clock cycles
    // ------------------------------------------------------------
    localparam logic [23:0] DEBOUNCE_RESET = 24'h000019;
    localparam logic [23:0] EXPOSURE_RESET = 24'h0003E8;
    localparam logic [23:0] READOUT_RESET = 24'h0003E8;
    localparam logic [23:0] COUNT_ONE = 24'h000001;

    // Status register bit positions
    localparam int STAT_EXPOSING_BIT = 0;
    localparam int STAT_READOUT_BIT = 1;
    localparam int STAT_FILTERED_BIT = 2;
    localparam int STAT_WAIT_BIT = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXPOSE = 2'b01,
        ST_READOUT = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [23:0] debounce;
        logic [23:0] exposure;
        logic [23:0] readout;
        logic sw_trig;
        logic raw;
        logic filt;
        logic filt_prev;
        logic [23:0] deb_cnt;
        seq_state_t state;
        logic [23:0] cnt;
        logic exposing;
        logic trig_wait;
        apb_rsp_t rsp;
    } seq_regs_t;

endpackage
`default_nettype wire

// ==== hw/trigger_exposure_sequencer.sv ====
// Functional notes
// - Pulse mode, positive polarity: expose from rising edge to next falling edge.
// - Pulse mode, negative polarity: expose from falling edge to next rising edge.
// - Pulse mode exposure length equals filtered active level time, preset ignored.
// - Edge mode starts on selected active edge and runs preset exposure time.
// - Edge mode with overlap rejection drops edges during exposure or image output.
// - Active pulses shorter than debounce time are filtered and have no effect.
// - Exposing output is high during the whole exposure, low afterwards.
// - Trigger-wait output low from exposure start until image output ends.
//
// Added by the designer: the address map and the APB slave port.
`default_nettype none
module trigger_exposure_sequencer
    import trig_seq_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // APB register bus
    input wire apb_req_t apb_in,
    output apb_rsp_t apb_out,
    // Trigger lines
    input wire logic isolated_trigger_input_in,
    input wire logic collector_bidir_line_in,
    output logic collector_bidir_line_out,
    output logic collector_bidir_line_oe_n_out,
    // Camera status
    output logic exposing_out,
    output logic trigger_wait_out,
    output logic readout_active_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    seq_regs_t r_q;
    seq_regs_t r_d;

    logic sel_raw;
    logic active_lvl;
    logic rise;
    logic fall;
    logic start_edge;
    logic end_edge;
    logic hw_start;
    logic go;
    logic busy;
    logic wr_en;
    logic rd_en;

    // ------------------------------------------------------------
    // Trigger source selection and edge decode
    // ------------------------------------------------------------
    // Source picks the isolated input or the collector line
    assign sel_raw = r_q.ctrl[CTRL_SRC_BIT] ? collector_bidir_line_in : isolated_trigger_input_in;
    // Polarity folds into the active level
    assign active_lvl = sel_raw ^ r_q.ctrl[CTRL_NEG_POL_BIT];
    assign rise = r_q.filt & ~r_q.filt_prev;
    assign fall = ~r_q.filt & r_q.filt_prev;
    // Filtered level is polarity-normalised, so rise is always the active edge
    assign start_edge = rise;
    assign end_edge = fall;
    assign hw_start = start_edge | r_q.sw_trig;
    assign busy = r_q.state != ST_IDLE;
    assign go = r_q.ctrl[CTRL_ENABLE_BIT] & hw_start &
        ~(busy & r_q.ctrl[CTRL_OVERLAP_BIT]);
    assign wr_en = apb_in.psel & apb_in.penable & apb_in.pwrite;
    assign rd_en = apb_in.psel & ~apb_in.penable & ~apb_in.pwrite;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.sw_trig = 1'b0;
        r_d.rsp.pready = 1'b1;
        r_d.rsp.pslverr = 1'b0;

        // Debounce: level change accepted only after stable for debounce time
        r_d.raw = active_lvl;
        r_d.filt_prev = r_q.filt;
        if (r_q.raw == r_q.filt) begin
            r_d.deb_cnt = '0;
        end else if (r_q.deb_cnt >= r_q.debounce) begin
            r_d.filt = r_q.raw;
            r_d.deb_cnt = '0;
        end else begin
            r_d.deb_cnt = r_q.deb_cnt + COUNT_ONE;
        end

        // Exposure sequencer
        unique case (r_q.state)
            ST_IDLE: begin
                if (go) begin
                    r_d.state = ST_EXPOSE;
                    r_d.cnt = r_q.exposure;
                    r_d.exposing = 1'b1;
                    r_d.trig_wait = 1'b0;
                end
            end
            ST_EXPOSE: begin
                if (r_q.ctrl[CTRL_PULSE_MODE_BIT]) begin
                    // Pulse mode ends on the filtered inactive edge
                    if (end_edge) begin
                        r_d.state = ST_READOUT;
                        r_d.cnt = r_q.readout;
                        r_d.exposing = 1'b0;
                    end
                end else if (r_q.cnt <= COUNT_ONE) begin
                    r_d.state = ST_READOUT;
                    r_d.cnt = r_q.readout;
                    r_d.exposing = 1'b0;
                end else begin
                    r_d.cnt = r_q.cnt - COUNT_ONE;
                end
            end
            ST_READOUT: begin
                if (r_q.cnt <= COUNT_ONE) begin
                    if (go) begin
                        // Overlap allowed: an edge in the last readout cycle restarts at once
                        r_d.state = ST_EXPOSE;
                        r_d.cnt = r_q.exposure;
                        r_d.exposing = 1'b1;
                    end else begin
                        r_d.state = ST_IDLE;
                        r_d.trig_wait = 1'b1;
                    end
                end else begin
                    r_d.cnt = r_q.cnt - COUNT_ONE;
                end
            end
            default: begin
                r_d.state = ST_IDLE;
                r_d.exposing = 1'b0;
                r_d.trig_wait = 1'b1;
            end
        endcase

        // APB writes take effect in the access phase
        if (wr_en) begin
            unique case (apb_in.paddr)
                ADDR_CTRL: r_d.ctrl = apb_in.pwdata;
                ADDR_DEBOUNCE: r_d.debounce = apb_in.pwdata[23:0];
                ADDR_EXPOSURE: r_d.exposure = apb_in.pwdata[23:0];
                ADDR_READOUT: r_d.readout = apb_in.pwdata[23:0];
                ADDR_SWTRIG: r_d.sw_trig = apb_in.pwdata[0];
                ADDR_STATUS: r_d.rsp.pslverr = 1'b0;
                default: r_d.rsp.pslverr = 1'b1;
            endcase
        end

        // APB read data registered in the setup phase
        if (rd_en) begin
            r_d.rsp.prdata = '0;
            unique case (apb_in.paddr)
                ADDR_CTRL: r_d.rsp.prdata = r_q.ctrl;
                ADDR_DEBOUNCE: r_d.rsp.prdata = {8'h00, r_q.debounce};
                ADDR_EXPOSURE: r_d.rsp.prdata = {8'h00, r_q.exposure};
                ADDR_READOUT: r_d.rsp.prdata = {8'h00, r_q.readout};
                ADDR_SWTRIG: r_d.rsp.prdata = '0;
                ADDR_STATUS: begin
                    r_d.rsp.prdata[STAT_EXPOSING_BIT] = r_q.exposing;
                    r_d.rsp.prdata[STAT_READOUT_BIT] = r_q.state == ST_READOUT;
                    r_d.rsp.prdata[STAT_FILTERED_BIT] = r_q.filt;
                    r_d.rsp.prdata[STAT_WAIT_BIT] = r_q.trig_wait;
                end
                default: r_d.rsp.prdata = '0;
            endcase
        end else if (apb_in.psel & ~apb_in.penable) begin
            r_d.rsp.prdata = '0;
        end

        // Error flag only answers unmapped reads and writes in the access phase
        if (apb_in.psel & apb_in.penable & ~apb_in.pwrite) begin
            unique case (apb_in.paddr)
                ADDR_CTRL, ADDR_DEBOUNCE, ADDR_EXPOSURE, ADDR_READOUT,
                ADDR_SWTRIG, ADDR_STATUS: r_d.rsp.pslverr = 1'b0;
                default: r_d.rsp.pslverr = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r_q <= '0;
            r_q.ctrl <= CTRL_RESET;
            r_q.debounce <= DEBOUNCE_RESET;
            r_q.exposure <= EXPOSURE_RESET;
            r_q.readout <= READOUT_RESET;
            r_q.state <= ST_IDLE;
            r_q.trig_wait <= 1'b1;
            r_q.rsp.pready <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answer: read data from flops, slverr combined with the access phase
    always_comb begin
        apb_out = r_q.rsp;
        apb_out.pready = 1'b1;
        apb_out.pslverr = apb_in.psel & apb_in.penable & r_q.rsp.pslverr & 1'b0;
        if (apb_in.psel & apb_in.penable) begin
            unique case (apb_in.paddr)
                ADDR_CTRL, ADDR_DEBOUNCE, ADDR_EXPOSURE, ADDR_READOUT,
                ADDR_SWTRIG, ADDR_STATUS: apb_out.pslverr = 1'b0;
                default: apb_out.pslverr = 1'b1;
            endcase
        end
    end

    assign exposing_out = r_q.exposing;
    assign trigger_wait_out = r_q.trig_wait;
    assign readout_active_out = r_q.state == ST_READOUT;
    // Collector line drives the wait signal when set as output; low enable means driving
    assign collector_bidir_line_out = r_q.trig_wait;
    assign collector_bidir_line_oe_n_out = ~r_q.ctrl[CTRL_LINE_OUT_BIT];

endmodule
`default_nettype wire

// ==== bench/trig_seq_monitor.sv ====
`default_nettype none
module trig_seq_monitor
    import trig_seq_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Register bus
    input wire apb_req_t apb_in,
    input wire apb_rsp_t apb_out,
    // Camera status
    input wire logic exposing_out,
    input wire logic trigger_wait_out,
    input wire logic readout_active_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // ------------------------------------------------------------
    // Exposure and image output sequencing
    // ------------------------------------------------------------
    exp_wait_a: assert property (exposing_out |-> !trigger_wait_out) else $error("wait high in exposure");
    ro_wait_a: assert property (readout_active_out |-> !trigger_wait_out) else $error("wait high in output");
    exp_end_a: assert property ($fell(exposing_out) |-> readout_active_out) else $error("no output");
    ro_start_a: assert property ($rose(readout_active_out) |-> $fell(exposing_out)) else $error("early output");
    wait_rise_a: assert property ($rose(trigger_wait_out) |-> $fell(readout_active_out)) else $error("early wait");
    wait_fall_a: assert property ($fell(trigger_wait_out) |-> $rose(exposing_out)) else $error("stray wait");
    // ------------------------------------------------------------
    // Register bus answers
    // ------------------------------------------------------------
    ready_now_a: assert property (apb_in.psel && apb_in.penable |-> apb_out.pready) else $error("wait state");
    err_phase_a: assert property (apb_out.pslverr |-> apb_in.psel && apb_in.penable) else $error("stray error");
endmodule

bind trigger_exposure_sequencer trig_seq_monitor mon (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .apb_in(apb_in), .apb_out(apb_out), .exposing_out(exposing_out), .trigger_wait_out(trigger_wait_out),
    .readout_active_out(readout_active_out));
`default_nettype wire

// ==== bench/trig_source.sv ====
`default_nettype none
module trig_source (
    // Clock
    input wire logic clk_in,
    // Trigger line
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_out = 1'b0;
    // Holds a level for n cycles, changing just after an edge
    task automatic hold(input logic lvl, input int n);
        @(posedge clk_in);
        line_out <= lvl;
        repeat (n - 1) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`default_nettype none
module tb
    import trig_seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, reset_n_in, iso, col_out, col_oe_n, exp_o, wait_o, ro_o;
    wire logic col_in;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [31:0] q;
    logic e;
    int fails = 0, checked = 0, starts = 0, ex_n = 0, ro_n = 0, s0, e0, r0;
    logic ex_prev = 1'b0;
    trigger_exposure_sequencer dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .apb_in(req), .apb_out(rsp),
        .isolated_trigger_input_in(iso), .collector_bidir_line_in(col_in), .collector_bidir_line_out(col_out),
        .collector_bidir_line_oe_n_out(col_oe_n), .exposing_out(exp_o), .trigger_wait_out(wait_o),
        .readout_active_out(ro_o));
    trig_source src (.clk_in(mclk_in), .line_out(iso));
    // Pull-up on the collector line when released
    assign col_in = col_oe_n ? 1'b1 : col_out;
    // ------------------------------------------------------------
    // Clock, activity counters and checks
    // ------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        ex_n += exp_o;
        ro_n += ro_o;
        if (exp_o && !ex_prev) starts++;
        ex_prev = exp_o;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_in);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge mclk_in);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        // A transfer that never completes counts as a mismatch
        if (rsp.pready !== 1'b1) fails++;
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(q, x);
        chk(e, xe);
    endtask
    task automatic mark();
        s0 = starts;
        e0 = ex_n;
        r0 = ro_n;
    endtask
    // Waits, then compares exposure starts and cycle counts
    task automatic expect3(input string nm, input int k, input int st, input int ex, input int ro);
        repeat (k) @(posedge mclk_in);
        chk(starts - s0, st);
        chk(ex_n - e0, ex);
        chk(ro_n - r0, ro);
        $display("%s done", nm);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({exp_o, wait_o, ro_o, col_oe_n}, 32'h5);
        rdc(ADDR_CTRL, CTRL_RESET, 1'b0);
        rdc(ADDR_DEBOUNCE, {8'h00, DEBOUNCE_RESET}, 1'b0);
        rdc(ADDR_EXPOSURE, {8'h00, EXPOSURE_RESET}, 1'b0);
        rdc(ADDR_READOUT, {8'h00, READOUT_RESET}, 1'b0);
        rdc(12'h020, 32'h0, 1'b1);
        $display("reset done");
    endtask
    task automatic t_edge();
        apb(1'b1, ADDR_DEBOUNCE, 32'h4);
        apb(1'b1, ADDR_EXPOSURE, 32'hA);
        apb(1'b1, ADDR_READOUT, 32'h8);
        apb(1'b1, ADDR_CTRL, 32'h11);
        mark();
        src.hold(1'b1, 8);
        // Low gap long enough to pass the filter, so the second edge lands in image output
        src.hold(1'b0, 6);
        src.hold(1'b1, 8);
        src.hold(1'b0, 1);
        expect3("edge", 40, 1, 10, 8);
    endtask
    task automatic t_glitch();
        mark();
        src.hold(1'b1, 3);
        src.hold(1'b0, 20);
        apb(1'b1, ADDR_CTRL, 32'h10);
        src.hold(1'b1, 8);
        src.hold(1'b0, 20);
        expect3("glitch", 5, 0, 0, 0);
    endtask
    task automatic t_pulse();
        apb(1'b1, ADDR_CTRL, 32'h13);
        mark();
        src.hold(1'b1, 30);
        src.hold(1'b0, 10);
        expect3("pulse", 30, 1, 30, 8);
    endtask
    task automatic t_neg();
        apb(1'b1, ADDR_CTRL, 32'h0);
        src.hold(1'b1, 10);
        apb(1'b1, ADDR_CTRL, 32'h17);
        src.hold(1'b1, 10);
        mark();
        src.hold(1'b0, 20);
        src.hold(1'b1, 10);
        expect3("neg", 30, 1, 20, 8);
    endtask
    task automatic t_sw();
        // Settle the filtered line inactive while disabled, so only software starts exposure
        apb(1'b1, ADDR_CTRL, 32'h30);
        src.hold(1'b0, 10);
        apb(1'b1, ADDR_CTRL, 32'h31);
        mark();
        apb(1'b1, ADDR_SWTRIG, 32'h1);
        apb(1'b1, ADDR_SWTRIG, 32'h1);
        expect3("soft", 40, 1, 10, 8);
        chk({col_oe_n, col_in}, 32'h1);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        req = '0;
        reset_n_in = 1'b0;
        repeat (12) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_edge();
        t_glitch();
        t_pulse();
        t_neg();
        t_sw();
        end_sim();
    end
    initial begin
        #(40 * 20000);
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
